// ---- rtl/mpio_top.sv ----
// Purpose : port A to E pin logic with wishbone register access
// Assumes : pins and peripheral signals synchronous to clk_i
// Notes   : every pad control is registered, one cycle behind its cause
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "mpio_defines.svh"

// Function
// - output bit drives latch; read returns latch
// - input bit read returns pin level
// - port A open-drain selects kill high drive
// - port A pullups per nibble, off when low
// - port B wake-up per bit, read unchanged
// - port B pullups per nibble
// - port C 7/6 read by dir; flags from read
// - event output owns C5; dir picks read
// - C4/C3 follow dir even as timer inputs
// - compare output owns C2 while enabled
// - C1/C0 serial while enabled, else io
// - port C pullup per bit, off when low
// - C5..C0 open-drain also for peripheral outputs
// - port D select bits 7-4, reset lcd
// - reset: port D disconnected, latch all ones
// - unused backplanes become port D outputs
// - port D open-drain nibble/three bits, not lcd
// - port E select per bit, reset disconnected
// - port E open-drain per nibble, not lcd
// - reset clears all direction bits
// - data write always updates latch
module mpio_top (
   // clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output      logic [31:0]       wb_dat_o,
   output      logic              wb_ack_o,
   // pin levels
   input  wire logic [7:0]        pa_pin_i,
   input  wire logic [7:0]        pb_pin_i,
   input  wire logic [7:0]        pc_pin_i,
   // peripheral side
   input  wire logic              timer_event_out_en_i,
   input  wire logic              timer_event_out_i,
   input  wire logic              compare_en_i,
   input  wire logic              compare_output_i,
   input  wire logic              serial_tx_enable_i,
   input  wire logic              serial_rx_enable_i,
   input  wire logic              serial_tx_data_i,
   input  wire logic              lcd_duty_quarter_i,
   input  wire logic [3:0]        lcd_bp_unused_i,
   output      logic              timer_event_in_o,
   output      logic              capture_input_o,
   output      logic              serial_rx_in_o,
   output      logic              key_wakeup_req_o,
   output      logic [1:0]        ext_irq_o,
   // pad controls
   output      mpio_pkg::mpio_pad_s pad_a_o,
   output      mpio_pkg::mpio_pad_s pad_b_o,
   output      mpio_pkg::mpio_pad_s pad_c_o,
   output      mpio_pkg::mpio_pad_s pad_d_o,
   output      mpio_pkg::mpio_pad_s pad_e_o,
   output      logic [7:0]        pd_lcd_own_o,
   output      logic [7:0]        pe_lcd_own_o
);
   import mpio_pkg::*;

   logic [7:0] lat_a_q, lat_b_q, lat_c_q, lat_d_q, lat_e_q;
   logic [7:0] dir_a_q, dir_b_q, dir_c_q;
   logic [7:0] pd_sel_q, pe_sel_q;
   logic [7:0] pu1_q, pu2_q, od1_q, od2_q, kwe_q;
   logic [1:0] irq_flag_q, irq_en_q, irq_src_q;
   logic       ack_q;
   logic       req, wr;
   logic [7:0] wdat;
   logic [7:0] rd_a, rd_b, rd_c, rdat_d;
   logic [1:0] irq_src, irq_fall, irq_clr;
   logic       sci_on;
   logic [7:0] en_c, dat_c, sel_d;
   logic [7:0] od_a, od_c, od_d, od_e, pu_a, pu_b;
   mpio_pad_s  pa_d, pb_d, pc_d, pd_d, pe_d;

   // pad function: open drain cuts only the high drive; pull off when low
   function automatic mpio_pad_s pad_f(input logic [7:0] en,
                                      input logic [7:0] d,
                                      input logic [7:0] od,
                                      input logic [7:0] pu);
      mpio_pad_s p;
      p.dout = d;
      p.oe_n = ~(en & ~(od & d));
      p.pull = pu & ~(en & ~d);
      return p;
   endfunction

   // bus request; ack_q blocks a second take of the same request
   assign req  = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr   = req & wb_we_i & wb_sel_i[0];
   assign wdat = wb_dat_i[7:0];

   // read source per bit: latch when output, pin when input
   assign rd_a = (dir_a_q & lat_a_q) | (~dir_a_q & pa_pin_i);
   assign rd_b = (dir_b_q & lat_b_q) | (~dir_b_q & pb_pin_i);
   assign rd_c = (dir_c_q & lat_c_q) | (~dir_c_q & pc_pin_i);

   // handshake: one wait state, ack lasts one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= req;
      end
   end

   // data latches; written whatever the direction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_a_q <= `MPIO_RST_ZERO;
         lat_b_q <= `MPIO_RST_ZERO;
         lat_c_q <= `MPIO_RST_ZERO;
         lat_d_q <= `MPIO_RST_ONES;
         lat_e_q <= `MPIO_RST_ONES;
      end else if (ce_i && wr) begin
         case (wb_adr_i)
            `MPIO_OFS_PA_LAT: lat_a_q <= wdat;
            `MPIO_OFS_PB_LAT: lat_b_q <= wdat;
            `MPIO_OFS_PC_LAT: lat_c_q <= wdat;
            `MPIO_OFS_PD_LAT: lat_d_q <= wdat;
            `MPIO_OFS_PE_LAT: lat_e_q <= wdat;
            default: ;
         endcase
      end
   end

   // direction registers, all inputs after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_a_q <= `MPIO_RST_ZERO;
         dir_b_q <= `MPIO_RST_ZERO;
         dir_c_q <= `MPIO_RST_ZERO;
      end else if (ce_i && wr) begin
         case (wb_adr_i)
            `MPIO_OFS_PA_DIR: dir_a_q <= wdat;
            `MPIO_OFS_PB_DIR: dir_b_q <= wdat;
            `MPIO_OFS_PC_DIR: dir_c_q <= wdat;
            default: ;
         endcase
      end
   end

   // lcd mux selects; zero hands the pin to the lcd driver
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pd_sel_q <= `MPIO_RST_ZERO;
         pe_sel_q <= `MPIO_RST_ZERO;
      end else if (ce_i && wr) begin
         case (wb_adr_i)
            `MPIO_OFS_PD_SEL: pd_sel_q <= wdat & `MPIO_PD_SELMSK;
            `MPIO_OFS_PE_SEL: pe_sel_q <= wdat;
            default: ;
         endcase
      end
   end

   // pull-up, open-drain and wake-up option registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pu1_q <= `MPIO_RST_ZERO;
         pu2_q <= `MPIO_RST_ZERO;
         od1_q <= `MPIO_RST_ZERO;
         od2_q <= `MPIO_RST_OD2;
         kwe_q <= `MPIO_RST_ZERO;
      end else if (ce_i && wr) begin
         case (wb_adr_i)
            `MPIO_OFS_PU1: pu1_q <= wdat & `MPIO_PU1_MSK;
            `MPIO_OFS_PU2: pu2_q <= wdat;
            `MPIO_OFS_OD1: od1_q <= wdat & `MPIO_OD1_MSK;
            `MPIO_OFS_OD2: od2_q <= (wdat & `MPIO_OD2_MSK) | `MPIO_RST_OD2;
            `MPIO_OFS_KWE: kwe_q <= wdat;
            default: ;
         endcase
      end
   end

   // irq source is the read value, so pin or latch can set the flag
   assign irq_src  = {rd_c[6], rd_c[7]};
   assign irq_fall = irq_src_q & ~irq_src;
   assign irq_clr  = (wr && wb_adr_i == `MPIO_OFS_IRQ) ?
                     wdat[`MPIO_IRQ_F2:`MPIO_IRQ_F1] : 2'h0;

   // sticky flags: a fall in the clearing cycle still sets the flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_flag_q <= 2'h0;
         irq_en_q   <= 2'h0;
         irq_src_q  <= 2'h0;
      end else if (ce_i) begin
         irq_src_q  <= irq_src;
         irq_flag_q <= (irq_flag_q & ~irq_clr) | irq_fall;
         if (wr && wb_adr_i == `MPIO_OFS_IRQ) begin
            irq_en_q <= wdat[`MPIO_IRQ_E2:`MPIO_IRQ_E1];
         end
      end
   end

   // read mux; unmapped offsets read zero and still ack
   always_comb begin
      case (wb_adr_i)
         `MPIO_OFS_PA_LAT: rdat_d = rd_a;
         `MPIO_OFS_PA_DIR: rdat_d = dir_a_q;
         `MPIO_OFS_PB_LAT: rdat_d = rd_b;
         `MPIO_OFS_PB_DIR: rdat_d = dir_b_q;
         `MPIO_OFS_PC_LAT: rdat_d = rd_c;
         `MPIO_OFS_PC_DIR: rdat_d = dir_c_q;
         `MPIO_OFS_PD_LAT: rdat_d = lat_d_q;
         `MPIO_OFS_PD_SEL: rdat_d = pd_sel_q;
         `MPIO_OFS_PE_LAT: rdat_d = lat_e_q;
         `MPIO_OFS_PE_SEL: rdat_d = pe_sel_q;
         `MPIO_OFS_PU1:    rdat_d = pu1_q;
         `MPIO_OFS_PU2:    rdat_d = pu2_q;
         `MPIO_OFS_OD1:    rdat_d = od1_q;
         `MPIO_OFS_OD2:    rdat_d = od2_q;
         `MPIO_OFS_KWE:    rdat_d = kwe_q;
         `MPIO_OFS_IRQ:    rdat_d = {2'h0, irq_en_q, 2'h0, irq_flag_q};
         default:          rdat_d = `MPIO_RST_ZERO;
      endcase
   end

   // read data register, held between accesses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i && req && !wb_we_i) begin
         wb_dat_o <= {24'h00_0000, rdat_d};
      end
   end

   assign wb_ack_o = ack_q;

   // port A: nibble-wide open drain and pull-ups; port B: nibble-wide pull-ups, no open drain
   assign od_a = {{4{od1_q[`MPIO_OD1_PAH]}}, {4{od1_q[`MPIO_OD1_PAL]}}};
   assign pu_a = {{4{pu1_q[`MPIO_PU1_PAH]}}, {4{pu1_q[`MPIO_PU1_PAL]}}};
   assign pu_b = {{4{pu1_q[`MPIO_PU1_PBH]}}, {4{pu1_q[`MPIO_PU1_PBL]}}};
   assign pa_d = pad_f(dir_a_q, lat_a_q, od_a, pu_a);
   assign pb_d = pad_f(dir_b_q, lat_b_q, 8'h00, pu_b);

   // port C: peripherals take over data and enable, never the read
   assign sci_on = serial_tx_enable_i | serial_rx_enable_i;
   assign en_c = {dir_c_q[7:6],
                  timer_event_out_en_i | dir_c_q[5],
                  dir_c_q[4:3],
                  compare_en_i | dir_c_q[2],
                  sci_on ? serial_tx_enable_i : dir_c_q[1],
                  ~sci_on & dir_c_q[0]};
   assign dat_c = {lat_c_q[7:6],
                   timer_event_out_en_i ? timer_event_out_i : lat_c_q[5],
                   lat_c_q[4:3],
                   compare_en_i ? compare_output_i : lat_c_q[2],
                   sci_on ? serial_tx_data_i : lat_c_q[1],
                   lat_c_q[0]};
   assign od_c = {2'h0, od2_q[5:0]};
   assign pc_d = pad_f(en_c, dat_c, od_c, pu2_q);

   // port D: low nibble turns port where the duty leaves a backplane free
   assign sel_d = {pd_sel_q[7:4], lcd_bp_unused_i & {4{~lcd_duty_quarter_i}}};
   assign od_d  = {{4{od1_q[`MPIO_OD1_PDH]}}, 1'b0,
                   {3{od1_q[`MPIO_OD1_PDL]}}};
   assign pd_d  = pad_f(sel_d, lat_d_q, od_d, 8'h00);

   // port E: lcd pins are undriven by the port, so open drain cannot reach them
   assign od_e = {{4{od1_q[`MPIO_OD1_PEH]}}, {4{od1_q[`MPIO_OD1_PEL]}}};
   assign pe_d = pad_f(pe_sel_q, lat_e_q, od_e, 8'h00);

   // pad registers; reset leaves every pin undriven
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_a_o      <= '{dout: `MPIO_RST_ZERO, oe_n: `MPIO_RST_ONES, pull: `MPIO_RST_ZERO};
         pad_b_o      <= '{dout: `MPIO_RST_ZERO, oe_n: `MPIO_RST_ONES, pull: `MPIO_RST_ZERO};
         pad_c_o      <= '{dout: `MPIO_RST_ZERO, oe_n: `MPIO_RST_ONES, pull: `MPIO_RST_ZERO};
         pad_d_o      <= '{dout: `MPIO_RST_ONES, oe_n: `MPIO_RST_ONES, pull: `MPIO_RST_ZERO};
         pad_e_o      <= '{dout: `MPIO_RST_ONES, oe_n: `MPIO_RST_ONES, pull: `MPIO_RST_ZERO};
         pd_lcd_own_o <= `MPIO_RST_ONES;
         pe_lcd_own_o <= `MPIO_RST_ONES;
      end else if (ce_i) begin
         pad_a_o      <= pa_d;
         pad_b_o      <= pb_d;
         pad_c_o      <= pc_d;
         pad_d_o      <= pd_d;
         pad_e_o      <= pe_d;
         pd_lcd_own_o <= ~sel_d;
         pe_lcd_own_o <= ~pe_sel_q;
      end
   end

   // peripheral inputs and event levels; wake-up never touches the read path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_event_in_o <= 1'b0;
         capture_input_o  <= 1'b0;
         serial_rx_in_o   <= 1'b1;
         key_wakeup_req_o <= 1'b0;
         ext_irq_o        <= 2'h0;
      end else if (ce_i) begin
         timer_event_in_o <= pc_pin_i[4];
         capture_input_o  <= pc_pin_i[3];
         serial_rx_in_o   <= pc_pin_i[0];
         key_wakeup_req_o <= |(kwe_q & ~pb_pin_i);
         ext_irq_o        <= irq_flag_q & irq_en_q;
      end
   end

   // checks
   sequence s_rd_pa;
      ce_i && req && !wb_we_i && wb_adr_i == `MPIO_OFS_PA_LAT;
   endsequence

   sequence s_wr_pa;
      ce_i && wr && wb_adr_i == `MPIO_OFS_PA_LAT;
   endsequence

   a_pa_read_src: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rd_pa |=> wb_ack_o && wb_dat_o[7:0] == $past(rd_a))
      else $error("port A read source wrong");

   a_pa_latch_wr: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wr_pa |=> lat_a_q == $past(wdat) ##1 !wb_ack_o || !$past(ce_i))
      else $error("port A latch write lost");

   a_pa_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && od1_q[`MPIO_OD1_PAH] |=> &(pad_a_o.oe_n[7:4] | ~pad_a_o.dout[7:4]))
      else $error("port A high drive while open drain");

   a_pull_low_off: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> (pad_a_o.pull & ~pad_a_o.oe_n & ~pad_a_o.dout) == 8'h00
               && (pad_c_o.pull & ~pad_c_o.oe_n & ~pad_c_o.dout) == 8'h00)
      else $error("pull-up left on a low pin");

   a_kwi_level: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> key_wakeup_req_o == (|($past(kwe_q) & ~$past(pb_pin_i))))
      else $error("wake-up request wrong");

   a_irq_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && irq_fall[0] |=> irq_flag_q[0]
                              ##1 (ext_irq_o[0] == $past(irq_en_q[0])) || !$past(ce_i))
      else $error("irq flag not set by fall");

   a_evo_route: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i && timer_event_out_en_i |=> pad_c_o.dout[5] == $past(timer_event_out_i))
      else $error("event output not on pin");

   a_pe_lcd_undriven: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> &(pad_e_o.oe_n | $past(pe_sel_q)))
      else $error("port E drives an lcd pin");

   // the pad register leaves reset one edge late, so the release edge is skipped
   a_c0_serial_undriven: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i && (serial_tx_enable_i || serial_rx_enable_i) |=> pad_c_o.oe_n[0])
      else $error("port C0 driven while serial is on");

   a_pd_lcd_undriven: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && ce_i |=> (pd_lcd_own_o & ~pad_d_o.oe_n) == 8'h00)
      else $error("port D drives an lcd pin");

   a_reset_state: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> lat_d_q == 8'hFF && pad_d_o.oe_n == 8'hFF
                      && (dir_a_q | dir_b_q | dir_c_q) == 8'h00)
      else $error("reset state wrong");

endmodule

// ---- rtl/mpio_defines.svh ----
// Purpose : constants of the multi-port io block: offsets, fields, resets
// Assumes : byte addresses on a 32-bit bus, one register per word
// Notes   : registers hold 8 bits in the low lane, upper lanes read zero
`ifndef MPIO_DEFINES_SVH
`define MPIO_DEFINES_SVH

// register byte offsets
`define MPIO_OFS_PA_LAT  8'h00
`define MPIO_OFS_PA_DIR  8'h04
`define MPIO_OFS_PB_LAT  8'h08
`define MPIO_OFS_PB_DIR  8'h0C
`define MPIO_OFS_PC_LAT  8'h10
`define MPIO_OFS_PC_DIR  8'h14
`define MPIO_OFS_PD_LAT  8'h18
`define MPIO_OFS_PD_SEL  8'h1C
`define MPIO_OFS_PE_LAT  8'h20
`define MPIO_OFS_PE_SEL  8'h24
`define MPIO_OFS_PU1     8'h28
`define MPIO_OFS_PU2     8'h2C
`define MPIO_OFS_OD1     8'h30
`define MPIO_OFS_OD2     8'h34
`define MPIO_OFS_KWE     8'h38
`define MPIO_OFS_IRQ     8'h3C

// pullup_ctrl_one fields
`define MPIO_PU1_PAL 0
`define MPIO_PU1_PAH 1
`define MPIO_PU1_PBL 2
`define MPIO_PU1_PBH 3
// opendrain_ctrl_one fields
`define MPIO_OD1_PAL 0
`define MPIO_OD1_PAH 1
`define MPIO_OD1_PDL 2
`define MPIO_OD1_PDH 3
`define MPIO_OD1_PEL 4
`define MPIO_OD1_PEH 5
// external irq register: flags (write 1 clears) and enables
`define MPIO_IRQ_F1 0
`define MPIO_IRQ_F2 1
`define MPIO_IRQ_E1 4
`define MPIO_IRQ_E2 5

// reset values and write masks
`define MPIO_RST_ZERO  8'h00
`define MPIO_RST_ONES  8'hFF
`define MPIO_RST_OD2   8'hC0
`define MPIO_PD_SELMSK 8'hF0
`define MPIO_OD2_MSK   8'h3F
`define MPIO_OD1_MSK   8'h3F
`define MPIO_PU1_MSK   8'h0F
`define MPIO_IRQ_EMSK  8'h30

`endif

// ---- rtl/mpio_pkg.sv ----
// Purpose : types shared by the multi-port io block
// Assumes : eight pins per port
// Notes   : pad carrier groups data, enable and pull-up of one port
package mpio_pkg;

   // one port's pad controls; oe_n low while the pin is driven
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_n;
      logic [7:0] pull;
   } mpio_pad_s;

endpackage

// ---- tb/mpio_pins_model.sv ----
// Purpose : pin model for ports A to C as seen from outside the chip
// Assumes : outside drivers are weaker than pad drive and pull-ups
// Notes   : an undriven pin shows its pull-up, else the outside level
`timescale 1ns/1ps
module mpio_pins_model (
   // pad controls from the block
   input  wire mpio_pkg::mpio_pad_s pad_a_i,
   input  wire mpio_pkg::mpio_pad_s pad_b_i,
   input  wire mpio_pkg::mpio_pad_s pad_c_i,
   // levels of the outside drivers
   input  wire logic [7:0]          ext_a_i,
   input  wire logic [7:0]          ext_b_i,
   input  wire logic [7:0]          ext_c_i,
   // resolved pin levels
   output      logic [7:0]          pa_pin_o,
   output      logic [7:0]          pb_pin_o,
   output      logic [7:0]          pc_pin_o
);
   import mpio_pkg::*;

   // pad drive wins, then the pull-up, then the outside driver
   function automatic logic [7:0] lvl(mpio_pad_s p, logic [7:0] x);
      return (p.dout & ~p.oe_n) | (p.oe_n & (p.pull | x));
   endfunction

   // resolved levels, fed straight back to the block
   assign pa_pin_o = lvl(pad_a_i, ext_a_i);
   assign pb_pin_o = lvl(pad_b_i, ext_b_i);
   assign pc_pin_o = lvl(pad_c_i, ext_c_i);
endmodule

// ---- tb/test_multi_port_io_with_lcd_mux.sv ----
// Purpose : self-checking bench of the multi-port io block
// Assumes : 20 MHz clock, classic wishbone single cycles
// Notes   : a register model predicts pads, status outputs but irq, and reads of all registers but the irq one
`timescale 1ns/1ps
`include "mpio_defines.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; \
   $display("MISMATCH %s exp %0h seen %0h", n, e, a); end end
module test_multi_port_io_with_lcd_mux;
   import mpio_pkg::*;
   // clock, reset, bus
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dw = 32'h0;
   logic [31:0] dr;
   logic        ack;
   // peripherals: evo en/val, cmp en/val, tx en, rx en, txd, quarter, bp unused
   logic [11:0] pv = 12'h080;
   logic [7:0]  ext [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0]  pin [3];
   mpio_pad_s   pad [5];
   logic [7:0]  pd_own;
   logic [7:0]  pe_own;
   logic        timer_event_in;
   logic        cap;
   logic        rxi;
   logic        kwu;
   logic [1:0]  irq;
   // register model, indexed by offset / 4
   logic [7:0]  m [16];
   int          errors = 0;
   int          compares = 0;
   integer      seed = 60;

   always #25 clk_i = ~clk_i;

   mpio_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
      .wb_dat_o(dr), .wb_ack_o(ack), .pa_pin_i(pin[0]), .pb_pin_i(pin[1]),
      .pc_pin_i(pin[2]), .timer_event_out_en_i(pv[0]), .timer_event_out_i(pv[1]),
      .compare_en_i(pv[2]), .compare_output_i(pv[3]), .serial_tx_enable_i(pv[4]),
      .serial_rx_enable_i(pv[5]), .serial_tx_data_i(pv[6]),
      .lcd_duty_quarter_i(pv[7]), .lcd_bp_unused_i(pv[11:8]),
      .timer_event_in_o(timer_event_in), .capture_input_o(cap), .serial_rx_in_o(rxi),
      .key_wakeup_req_o(kwu), .ext_irq_o(irq), .pad_a_o(pad[0]), .pad_b_o(pad[1]),
      .pad_c_o(pad[2]), .pad_d_o(pad[3]), .pad_e_o(pad[4]), .pd_lcd_own_o(pd_own),
      .pe_lcd_own_o(pe_own));

   mpio_pins_model pins_u (.pad_a_i(pad[0]), .pad_b_i(pad[1]), .pad_c_i(pad[2]),
      .ext_a_i(ext[0]), .ext_b_i(ext[1]), .ext_c_i(ext[2]),
      .pa_pin_o(pin[0]), .pb_pin_o(pin[1]), .pc_pin_o(pin[2]));

   // port D pins owned by the port: select bits plus spare backplanes
   function automatic logic [7:0] dsel();
      return m[7] | (pv[7] ? 8'h00 : {4'h0, pv[11:8]});
   endfunction

   // expected pad of port p as {driven value, oe_n, pull}
   function automatic logic [23:0] pad_x(int p);
      logic [7:0] drv;
      logic [7:0] dv;
      logic [7:0] odm;
      logic [7:0] pum;
      logic [7:0] oe;
      drv = (p == 3) ? dsel() : m[2*p+1];
      dv  = m[2*p];
      odm = 8'h00;
      pum = 8'h00;
      case (p)
         0: begin
            odm = {{4{m[12][1]}}, {4{m[12][0]}}};
            pum = {{4{m[10][1]}}, {4{m[10][0]}}};
         end
         1: pum = {{4{m[10][3]}}, {4{m[10][2]}}};
         2: begin
            drv[5] = drv[5] | pv[0];
            dv[5] = pv[0] ? pv[1] : dv[5];
            drv[2] = drv[2] | pv[2];
            dv[2] = pv[2] ? pv[3] : dv[2];
            if (pv[4] | pv[5]) begin
               drv[1:0] = {pv[4], 1'b0};
               dv[1] = pv[6];
            end
            odm = m[13] & 8'h3F;
            pum = m[11];
         end
         3: odm = {{4{m[12][3]}}, 1'b0, {3{m[12][2]}}};
         default: odm = {{4{m[12][5]}}, {4{m[12][4]}}};
      endcase
      oe = ~drv | (odm & dv);
      return {dv & ~oe, oe, pum & (oe | dv)};
   endfunction

   function automatic logic [7:0] pin_x(int p);
      logic [23:0] x;
      x = pad_x(p);
      return x[23:16] | (x[15:8] & (x[7:0] | ext[p]));
   endfunction

   // port latch reads pick latch or pin by direction, others read back
   function automatic logic [7:0] rd_x(int i);
      if (i < 6 && i % 2 == 0) return (m[i+1] & m[i]) | (~m[i+1] & pin_x(i / 2));
      return m[i];
   endfunction

   // one classic cycle; the request stands until ack is sampled high
   task automatic bus(input int i, input logic w, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= 8'(i * 4);
      sel <= s;
      dw  <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      q = dr;
      `CHK("ack", 1'b1, ack)
      `CHK("ack wait", 2, n)
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s);
      logic [31:0] q;
      bus(i, 1'b1, d, s, q);
      if (s[0] && i < 15) begin
         case (i)
            7: m[i] = d & `MPIO_PD_SELMSK;
            10: m[i] = d & `MPIO_PU1_MSK;
            12: m[i] = d & `MPIO_OD1_MSK;
            13: m[i] = (d & `MPIO_OD2_MSK) | `MPIO_RST_OD2;
            default: m[i] = d;
         endcase
      end
   endtask

   task automatic rd(input int i, input logic [7:0] e);
      logic [31:0] q;
      bus(i, 1'b0, 8'h00, 4'hF, q);
      `CHK($sformatf("reg %0d", i), {24'h0, e}, q)
   endtask

   // pads, lcd ownership, status outputs other than irq, and every register but the irq one
   task automatic chk_all();
      logic [7:0] c;
      repeat (4) @(posedge clk_i);
      c = pin_x(2);
      for (int p = 0; p < 5; p++) begin
         `CHK("pad", pad_x(p), {pad[p].dout & ~pad[p].oe_n, pad[p].oe_n, pad[p].pull})
      end
      `CHK("pd_own", ~dsel(), pd_own)
      `CHK("pe_own", ~m[9], pe_own)
      `CHK("kwu", |(m[14] & ~pin_x(1)), kwu)
      `CHK("timer in", {c[4], c[3], c[0]}, {timer_event_in, cap, rxi})
      for (int i = 0; i < 15; i++) rd(i, rd_x(i));
   endtask

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (m[i]) m[i] = `MPIO_RST_ZERO;
      m[6] = `MPIO_RST_ONES;
      m[8] = `MPIO_RST_ONES;
      m[13] = `MPIO_RST_OD2;
   endtask

   task automatic end_sim();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // a hang is cut well past the few thousand cycles the run needs
   initial begin
      #1000000;
      errors++;
      end_sim();
   end

   // reset values, random traffic, freeze, irq flags, unmapped place, second reset
   initial begin
      int i;
      logic [7:0] d;
      logic [51:0] hold;
      do_reset();
      chk_all();
      for (int k = 0; k < 60; k++) begin
         i = $unsigned($random(seed)) % 15;
         d = 8'($random(seed));
         // the timer event pin C4 is kept an input, the other port C directions move freely
         if (i == 5) d[4] = 1'b0;
         if (i == 3) d = d & ~m[14];
         if (i == 14) d = d & ~m[3];
         @(posedge clk_i);
         pv <= 12'($random(seed));
         for (int p = 0; p < 3; p++) ext[p] <= 8'($random(seed));
         wr(i, d, {3'h7, ($random(seed) & 3) != 0});
         chk_all();
      end
      // clock enable low: pins and peripherals move, pads A and C and the status flops other than irq must hold
      hold = {pad[0], pad[2], timer_event_in, cap, rxi, kwu};
      @(posedge clk_i);
      ce <= 1'b0;
      pv <= ~pv;
      for (int p = 0; p < 3; p++) ext[p] <= ~ext[p];
      repeat (4) @(posedge clk_i);
      `CHK("frozen", hold, {pad[0], pad[2], timer_event_in, cap, rxi, kwu})
      ce <= 1'b1;
      chk_all();
      wr(11, 8'h00, 4'hF);
      wr(5, 8'h40, 4'hF);
      wr(4, 8'h40, 4'hF);
      ext[2][7] <= 1'b1;
      repeat (3) @(posedge clk_i);
      wr(15, 8'h03, 4'hF);
      wr(15, 8'h30, 4'hF);
      ext[2][7] <= 1'b0;
      repeat (4) @(posedge clk_i);
      `CHK("irq", 2'b01, irq)
      wr(4, 8'h00, 4'hF);
      repeat (4) @(posedge clk_i);
      `CHK("irq", 2'b11, irq)
      rd(15, 8'h33);
      wr(15, 8'h31, 4'hF);
      repeat (4) @(posedge clk_i);
      `CHK("irq", 2'b10, irq)
      rd(15, 8'h32);
      wr(16, 8'h5A, 4'hF);
      rd(16, 8'h00);
      chk_all();
      do_reset();
      chk_all();
      end_sim();
   end
endmodule
